//--- rtl/tah_top.sv
// Threshold registers, three hysteresis alerts and their event interrupt.
//
// Decided for this implementation: the strobed register port.
`timescale 1ns/1ps
module tah_top (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst_n,
  // Register port
  input wire logic [tah_pkg::ADDR_W-1:0] reg_addr,
  input wire logic [tah_pkg::DATA_W-1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [tah_pkg::DATA_W-1:0] reg_rdata,
  // Measurement engine
  input wire logic meas_valid,
  input wire logic meas_bipolar,
  input wire logic meas_block,
  input wire logic [tah_pkg::THR_W-1:0] meas_code,
  // Alerts and interrupt
  output logic cell_overvoltage_alert,
  output logic cell_undervoltage_alert,
  output logic block_overvoltage_alert,
  output logic irq
);

  // ****************************************************************
  // Reset release
  // ****************************************************************
  logic rst_meta_n;
  logic rst_sync_n;

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      rst_meta_n <= 1'b0;
      rst_sync_n <= 1'b0;
    end else begin
      rst_meta_n <= 1'b1;
      rst_sync_n <= rst_meta_n;
    end
  end

  // ****************************************************************
  // Threshold registers
  // ****************************************************************
  logic [tah_pkg::THR_W-1:0] bipolar_cell_ov_clear_threshold;
  logic [tah_pkg::THR_W-1:0] bipolar_cell_ov_set_threshold;
  logic [tah_pkg::THR_W-1:0] bipolar_cell_uv_clear_threshold;
  logic [tah_pkg::THR_W-1:0] bipolar_cell_uv_set_threshold;
  logic [tah_pkg::THR_W-1:0] block_ov_clear_threshold;
  logic [tah_pkg::THR_W-1:0] block_ov_set_threshold;
  logic [tah_pkg::THR_W-1:0] next_bip_ov_clr;
  logic [tah_pkg::THR_W-1:0] next_bip_ov_set;
  logic [tah_pkg::THR_W-1:0] next_bip_uv_clr;
  logic [tah_pkg::THR_W-1:0] next_bip_uv_set;
  logic [tah_pkg::THR_W-1:0] next_blk_ov_clr;
  logic [tah_pkg::THR_W-1:0] next_blk_ov_set;
  logic [tah_pkg::THR_W-1:0] wr_thr;

  // Only the upper fourteen bits are stored; bits 1:0 are dropped.
  assign wr_thr = reg_wdata[tah_pkg::THR_MSB:tah_pkg::THR_LSB];

  always_comb begin
    next_bip_ov_clr = bipolar_cell_ov_clear_threshold;
    next_bip_ov_set = bipolar_cell_ov_set_threshold;
    next_bip_uv_clr = bipolar_cell_uv_clear_threshold;
    next_bip_uv_set = bipolar_cell_uv_set_threshold;
    next_blk_ov_clr = block_ov_clear_threshold;
    next_blk_ov_set = block_ov_set_threshold;
    if (reg_wr) begin
      case (reg_addr)
        tah_pkg::OFS_BIP_OV_CLR: next_bip_ov_clr = wr_thr;
        tah_pkg::OFS_BIP_OV_SET: next_bip_ov_set = wr_thr;
        tah_pkg::OFS_BIP_UV_CLR: next_bip_uv_clr = wr_thr;
        tah_pkg::OFS_BIP_UV_SET: next_bip_uv_set = wr_thr;
        tah_pkg::OFS_BLK_OV_CLR: next_blk_ov_clr = wr_thr;
        tah_pkg::OFS_BLK_OV_SET: next_blk_ov_set = wr_thr;
        default: begin
        end
      endcase
    end
  end

  always_ff @(posedge sys_clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      bipolar_cell_ov_clear_threshold <= tah_pkg::RST_BIP_OV_CLR;
      bipolar_cell_ov_set_threshold <= tah_pkg::RST_BIP_OV_SET;
      bipolar_cell_uv_clear_threshold <= tah_pkg::RST_BIP_UV_CLR;
      bipolar_cell_uv_set_threshold <= tah_pkg::RST_BIP_UV_SET;
      block_ov_clear_threshold <= tah_pkg::RST_BLK_OV_CLR;
      block_ov_set_threshold <= tah_pkg::RST_BLK_OV_SET;
    end else begin
      bipolar_cell_ov_clear_threshold <= next_bip_ov_clr;
      bipolar_cell_ov_set_threshold <= next_bip_ov_set;
      bipolar_cell_uv_clear_threshold <= next_bip_uv_clr;
      bipolar_cell_uv_set_threshold <= next_bip_uv_set;
      block_ov_clear_threshold <= next_blk_ov_clr;
      block_ov_set_threshold <= next_blk_ov_set;
    end
  end

  // ****************************************************************
  // Alert flags
  // ****************************************************************
  logic cell_sample;
  logic block_sample;

  // Unipolar cell codes are handled elsewhere and never touch these flags.
  assign cell_sample = meas_valid && meas_bipolar && !meas_block;
  assign block_sample = meas_valid && meas_block;

  tah_hyst_alert #(.W(tah_pkg::THR_W), .OVER(1'b1)) u_cell_ov (
    .clk(sys_clk),
    .rst_n(rst_sync_n),
    .sample(cell_sample),
    .code(meas_code),
    .set_thr(bipolar_cell_ov_set_threshold),
    .clr_thr(bipolar_cell_ov_clear_threshold),
    .alert(cell_overvoltage_alert)
  );

  tah_hyst_alert #(.W(tah_pkg::THR_W), .OVER(1'b0)) u_cell_uv (
    .clk(sys_clk),
    .rst_n(rst_sync_n),
    .sample(cell_sample),
    .code(meas_code),
    .set_thr(bipolar_cell_uv_set_threshold),
    .clr_thr(bipolar_cell_uv_clear_threshold),
    .alert(cell_undervoltage_alert)
  );

  tah_hyst_alert #(.W(tah_pkg::THR_W), .OVER(1'b1)) u_blk_ov (
    .clk(sys_clk),
    .rst_n(rst_sync_n),
    .sample(block_sample),
    .code(meas_code),
    .set_thr(block_ov_set_threshold),
    .clr_thr(block_ov_clear_threshold),
    .alert(block_overvoltage_alert)
  );

  // ****************************************************************
  // Event status, enable and interrupt
  // ****************************************************************
  logic [tah_pkg::EV_W-1:0] alert_now;
  logic [tah_pkg::EV_W-1:0] alert_prev;
  logic [tah_pkg::EV_W-1:0] evt_status;
  logic [tah_pkg::EV_W-1:0] evt_enable;
  logic [tah_pkg::EV_W-1:0] evt_rise;
  logic [tah_pkg::EV_W-1:0] evt_clr;
  logic [tah_pkg::EV_W-1:0] next_status;
  logic [tah_pkg::EV_W-1:0] next_enable;
  logic next_irq;

  always_comb begin
    alert_now = '0;
    alert_now[tah_pkg::EV_CELL_OV] = cell_overvoltage_alert;
    alert_now[tah_pkg::EV_CELL_UV] = cell_undervoltage_alert;
    alert_now[tah_pkg::EV_BLK_OV] = block_overvoltage_alert;
  end

  // A new event is an alert that has just risen.
  assign evt_rise = alert_now & ~alert_prev;

  always_comb begin
    evt_clr = '0;
    next_enable = evt_enable;
    if (reg_wr && reg_addr == tah_pkg::OFS_EVT_CLEAR) begin
      evt_clr = reg_wdata[tah_pkg::EV_W-1:0];
    end
    if (reg_wr && reg_addr == tah_pkg::OFS_EVT_ENABLE) begin
      next_enable = reg_wdata[tah_pkg::EV_W-1:0];
    end
    // A rise in the clearing cycle survives the clear.
    next_status = (evt_status & ~evt_clr) | evt_rise;
    next_irq = |(next_status & next_enable);
  end

  always_ff @(posedge sys_clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      alert_prev <= '0;
      evt_status <= '0;
      evt_enable <= '0;
      irq <= 1'b0;
    end else begin
      alert_prev <= alert_now;
      evt_status <= next_status;
      evt_enable <= next_enable;
      irq <= next_irq;
    end
  end

  // ****************************************************************
  // Read data
  // ****************************************************************
  logic [tah_pkg::DATA_W-1:0] next_rdata;

  always_comb begin
    next_rdata = '0;
    if (reg_rd) begin
      case (reg_addr)
        tah_pkg::OFS_BIP_OV_CLR: next_rdata[tah_pkg::THR_MSB:
          tah_pkg::THR_LSB] = bipolar_cell_ov_clear_threshold;
        tah_pkg::OFS_BIP_OV_SET: next_rdata[tah_pkg::THR_MSB:
          tah_pkg::THR_LSB] = bipolar_cell_ov_set_threshold;
        tah_pkg::OFS_BIP_UV_CLR: next_rdata[tah_pkg::THR_MSB:
          tah_pkg::THR_LSB] = bipolar_cell_uv_clear_threshold;
        tah_pkg::OFS_BIP_UV_SET: next_rdata[tah_pkg::THR_MSB:
          tah_pkg::THR_LSB] = bipolar_cell_uv_set_threshold;
        tah_pkg::OFS_BLK_OV_CLR: next_rdata[tah_pkg::THR_MSB:
          tah_pkg::THR_LSB] = block_ov_clear_threshold;
        tah_pkg::OFS_BLK_OV_SET: next_rdata[tah_pkg::THR_MSB:
          tah_pkg::THR_LSB] = block_ov_set_threshold;
        tah_pkg::OFS_ALERT_NOW: next_rdata[tah_pkg::EV_W-1:0] = alert_now;
        tah_pkg::OFS_EVT_STATUS: next_rdata[tah_pkg::EV_W-1:0] = evt_status;
        tah_pkg::OFS_EVT_ENABLE: next_rdata[tah_pkg::EV_W-1:0] = evt_enable;
        default: next_rdata = '0;
      endcase
    end
  end

  always_ff @(posedge sys_clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      reg_rdata <= '0;
    end else begin
      reg_rdata <= next_rdata;
    end
  end

  // ****************************************************************
  // Assertions
  // ****************************************************************
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!rst_sync_n);

  property p_cell_ov_set;
    cell_sample && meas_code > bipolar_cell_ov_set_threshold &&
      bipolar_cell_ov_set_threshold != tah_pkg::OV_OFF
      |=> cell_overvoltage_alert;
  endproperty
  a_cell_ov_set: assert property (p_cell_ov_set)
    else $error("cell overvoltage alert did not set");

  property p_cell_ov_off;
    bipolar_cell_ov_set_threshold == tah_pkg::OV_OFF &&
      !cell_overvoltage_alert |=> !cell_overvoltage_alert;
  endproperty
  a_cell_ov_off: assert property (p_cell_ov_off)
    else $error("disabled cell overvoltage alert rose");

  property p_cell_ov_clr;
    cell_sample && meas_code <= bipolar_cell_ov_clear_threshold &&
      !(meas_code > bipolar_cell_ov_set_threshold)
      |=> !cell_overvoltage_alert;
  endproperty
  a_cell_ov_clr: assert property (p_cell_ov_clr)
    else $error("cell overvoltage alert did not clear");

  property p_cell_uv_clr;
    cell_sample && meas_code >= bipolar_cell_uv_clear_threshold &&
      !(meas_code < bipolar_cell_uv_set_threshold)
      |=> !cell_undervoltage_alert;
  endproperty
  a_cell_uv_clr: assert property (p_cell_uv_clr)
    else $error("cell undervoltage alert did not clear");

  property p_cell_uv_set;
    cell_sample && meas_code < bipolar_cell_uv_set_threshold
      |=> cell_undervoltage_alert;
  endproperty
  a_cell_uv_set: assert property (p_cell_uv_set)
    else $error("cell undervoltage alert did not set");

  property p_cell_uv_off;
    bipolar_cell_uv_set_threshold == tah_pkg::UV_OFF &&
      !cell_undervoltage_alert |=> !cell_undervoltage_alert;
  endproperty
  a_cell_uv_off: assert property (p_cell_uv_off)
    else $error("disabled cell undervoltage alert rose");

  property p_blk_ov_clr;
    block_sample && meas_code <= block_ov_clear_threshold &&
      !(meas_code > block_ov_set_threshold)
      |=> !block_overvoltage_alert;
  endproperty
  a_blk_ov_clr: assert property (p_blk_ov_clr)
    else $error("block overvoltage alert did not clear");

  property p_blk_ov_set;
    block_sample && meas_code > block_ov_set_threshold &&
      block_ov_set_threshold != tah_pkg::OV_OFF
      |=> block_overvoltage_alert;
  endproperty
  a_blk_ov_set: assert property (p_blk_ov_set)
    else $error("block overvoltage alert did not set");

  property p_blk_ov_off;
    block_ov_set_threshold == tah_pkg::OV_OFF &&
      !block_overvoltage_alert |=> !block_overvoltage_alert;
  endproperty
  a_blk_ov_off: assert property (p_blk_ov_off)
    else $error("disabled block overvoltage alert rose");

  property p_hold_idle;
    !meas_valid |=> $stable(alert_now);
  endproperty
  a_hold_idle: assert property (p_hold_idle)
    else $error("alert changed without a measurement");

  property p_low_bits_zero;
    reg_rd && reg_addr >= tah_pkg::OFS_BIP_OV_CLR &&
      reg_addr <= tah_pkg::OFS_BLK_OV_SET |=> reg_rdata[1:0] == 2'h0;
  endproperty
  a_low_bits_zero: assert property (p_low_bits_zero)
    else $error("threshold low bits read nonzero");

  c_cell_ov_cycle: cover property (
    cell_overvoltage_alert ##[1:50] !cell_overvoltage_alert);
  c_cell_uv_set: cover property ($rose(cell_undervoltage_alert));
  c_blk_ov_irq: cover property ($rose(block_overvoltage_alert) ##2 irq);

endmodule

//--- inc/tah_pkg.sv
// Package of shared constants for the threshold alert hysteresis block.
package tah_pkg;

  // ****************************************************************
  // Bus and field geometry
  // ****************************************************************
  localparam int ADDR_W = 8;
  localparam int DATA_W = 16;
  localparam int THR_W = 14;
  localparam int THR_LSB = 2;
  localparam int THR_MSB = 15;

  // ****************************************************************
  // Register offsets
  // ****************************************************************
  localparam logic [7:0] OFS_BIP_OV_CLR = 8'h24;
  localparam logic [7:0] OFS_BIP_OV_SET = 8'h25;
  localparam logic [7:0] OFS_BIP_UV_CLR = 8'h26;
  localparam logic [7:0] OFS_BIP_UV_SET = 8'h27;
  localparam logic [7:0] OFS_BLK_OV_CLR = 8'h28;
  localparam logic [7:0] OFS_BLK_OV_SET = 8'h29;
  localparam logic [7:0] OFS_ALERT_NOW = 8'h30;
  localparam logic [7:0] OFS_EVT_STATUS = 8'h31;
  localparam logic [7:0] OFS_EVT_ENABLE = 8'h32;
  localparam logic [7:0] OFS_EVT_CLEAR = 8'h33;

  // ****************************************************************
  // Reset and disable values
  // ****************************************************************
  localparam logic [13:0] RST_BIP_OV_CLR = 14'h3fff;
  localparam logic [13:0] RST_BIP_OV_SET = 14'h3fff;
  localparam logic [13:0] RST_BIP_UV_CLR = 14'h0000;
  localparam logic [13:0] RST_BIP_UV_SET = 14'h0000;
  localparam logic [13:0] RST_BLK_OV_CLR = 14'h3fff;
  localparam logic [13:0] RST_BLK_OV_SET = 14'h3fff;
  localparam logic [13:0] OV_OFF = 14'h3fff;
  localparam logic [13:0] UV_OFF = 14'h0000;

  // ****************************************************************
  // Event bit layout of status, enable and clear
  // ****************************************************************
  localparam int EV_W = 3;
  localparam int EV_CELL_OV = 0;
  localparam int EV_CELL_UV = 1;
  localparam int EV_BLK_OV = 2;

endpackage

//--- rtl/tah_hyst_alert.sv
// One hysteresis alert flag with set and clear thresholds.
`timescale 1ns/1ps
module tah_hyst_alert #(
  parameter int W = 14,
  parameter bit OVER = 1'b1
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Measurement
  input wire logic sample,
  input wire logic [W-1:0] code,
  // Thresholds
  input wire logic [W-1:0] set_thr,
  input wire logic [W-1:0] clr_thr,
  // Flag
  output logic alert
);

  logic next_alert;
  logic hit_set;
  logic hit_clr;

  // Codes are offset binary, so a plain unsigned compare orders them.
  always_comb begin
    if (OVER) begin
      // An all-ones set threshold can never be exceeded by design.
      hit_set = (code > set_thr) && (set_thr != {W{1'b1}});
      hit_clr = (code <= clr_thr);
    end else begin
      hit_set = (code < set_thr);
      hit_clr = (code >= clr_thr);
    end
  end

  // Set wins if software programs overlapping thresholds, so a real
  // excursion is never hidden by a misconfiguration.
  always_comb begin
    next_alert = alert;
    if (sample) begin
      if (hit_set) begin
        next_alert = 1'b1;
      end else if (hit_clr) begin
        next_alert = 1'b0;
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      alert <= 1'b0;
    end else begin
      alert <= next_alert;
    end
  end

endmodule

//--- sim/testbench.sv
// Self-checking testbench for the threshold alert hysteresis block.
`timescale 1ns/1ps
module testbench;

  // ******************************************************************
  // Stimulus and observed signals
  // ******************************************************************
  logic sys_clk = 1'b0;
  logic rst_n = 1'b0;
  logic [7:0] reg_addr = 8'h00;
  logic [15:0] reg_wdata = 16'h0000;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [15:0] reg_rdata;
  logic meas_valid = 1'b0;
  logic meas_bipolar = 1'b0;
  logic meas_block = 1'b0;
  logic [13:0] meas_code = 14'h0000;
  logic cell_overvoltage_alert;
  logic cell_undervoltage_alert;
  logic block_overvoltage_alert;
  logic irq;
  int mismatches = 0;
  int tests_run = 0;

  always #12.5 sys_clk = ~sys_clk;

  tah_top u_tah_top (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .reg_addr(reg_addr),
    .reg_wdata(reg_wdata),
    .reg_wr(reg_wr),
    .reg_rd(reg_rd),
    .reg_rdata(reg_rdata),
    .meas_valid(meas_valid),
    .meas_bipolar(meas_bipolar),
    .meas_block(meas_block),
    .meas_code(meas_code),
    .cell_overvoltage_alert(cell_overvoltage_alert),
    .cell_undervoltage_alert(cell_undervoltage_alert),
    .block_overvoltage_alert(block_overvoltage_alert),
    .irq(irq)
  );

  // ******************************************************************
  // Shared tasks
  // ******************************************************************
  task automatic check(input logic [15:0] seen, input logic [15:0] exp,
                       input string msg);
    tests_run++;
    if (seen !== exp) begin
      mismatches++;
      $display("unexpected at %0t: %s seen %h expected %h", $time, msg,
               seen, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge sys_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
  endtask

  // Threshold lives in bits 15:2, so the code is shifted up two places.
  task automatic wr_thr(input logic [7:0] a, input logic [13:0] t);
    wr(a, {t, 2'b00});
  endtask

  // Read data stand only in the cycle after the strobe.
  task automatic rd_chk(input logic [7:0] a, input logic [15:0] exp,
                        input string msg);
    @(posedge sys_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    #1;
    check(reg_rdata, exp, msg);
  endtask

  // One measurement code; alerts are settled just after its edge.
  task automatic meas(input logic bip, input logic blk,
                      input logic [13:0] c);
    @(posedge sys_clk);
    meas_valid <= 1'b1;
    meas_bipolar <= bip;
    meas_block <= blk;
    meas_code <= c;
    @(posedge sys_clk);
    meas_valid <= 1'b0;
    #1;
  endtask

  task automatic irq_chk(input logic exp);
    @(posedge sys_clk);
    #1;
    check(irq, exp, "interrupt level");
  endtask

  // ******************************************************************
  // Scenarios
  // ******************************************************************
  task automatic t_reset_values;
    logic [15:0] exp [6];
    exp = '{16'hfffc, 16'hfffc, 16'h0000, 16'h0000, 16'hfffc, 16'hfffc};
    for (int i = 0; i < 6; i++) begin
      rd_chk(8'h24 + 8'(i), exp[i], "threshold reset value");
    end
    rd_chk(8'h40, 16'h0000, "unmapped read");
    rd_chk(8'h30, 16'h0000, "alerts after reset");
    check(irq, 1'b0, "interrupt after reset");
  endtask

  task automatic t_low_bits;
    wr(8'h25, 16'h1003);
    rd_chk(8'h25, 16'h1000, "low threshold bits");
    // Put the set threshold back to its disable value so that later cell
    // codes cannot raise the overvoltage alert and its enabled event.
    wr_thr(8'h25, 14'h3fff);
    rd_chk(8'h25, 16'hfffc, "set threshold disabled again");
    wr(8'h40, 16'hffff);
    rd_chk(8'h40, 16'h0000, "unmapped write");
    wr(8'h32, 16'h0001);
    rd_chk(8'h32, 16'h0001, "event enable");
  endtask

  task automatic t_cell_uv;
    wr_thr(8'h26, 14'h1000);
    wr_thr(8'h27, 14'h0800);
    meas(1'b1, 1'b0, 14'h0800);
    check(cell_undervoltage_alert, 1'b0, "uv at set");
    meas(1'b1, 1'b0, 14'h07ff);
    check(cell_undervoltage_alert, 1'b1, "uv below set");
    irq_chk(1'b0);
    meas(1'b1, 1'b0, 14'h0fff);
    check(cell_undervoltage_alert, 1'b1, "uv hold");
    meas(1'b1, 1'b0, 14'h1000);
    check(cell_undervoltage_alert, 1'b0, "uv at clear");
    wr_thr(8'h27, 14'h0000);
    meas(1'b1, 1'b0, 14'h0000);
    check(cell_undervoltage_alert, 1'b0, "uv disabled");
  endtask

  task automatic t_cell_ov;
    wr_thr(8'h24, 14'h0800);
    wr_thr(8'h25, 14'h1000);
    meas(1'b1, 1'b0, 14'h1000);
    check(cell_overvoltage_alert, 1'b0, "ov at set");
    meas(1'b0, 1'b0, 14'h3000);
    check(cell_overvoltage_alert, 1'b0, "ov unipolar code");
    meas(1'b1, 1'b0, 14'h1001);
    check(cell_overvoltage_alert, 1'b1, "ov above set");
    irq_chk(1'b1);
    rd_chk(8'h30, 16'h0001, "live alerts");
    rd_chk(8'h31, 16'h0003, "event status");
    meas(1'b0, 1'b0, 14'h0000);
    check(cell_overvoltage_alert, 1'b1, "ov unipolar hold");
    meas(1'b1, 1'b0, 14'h0801);
    check(cell_overvoltage_alert, 1'b1, "ov hold");
    meas(1'b1, 1'b0, 14'h0800);
    check(cell_overvoltage_alert, 1'b0, "ov at clear");
    wr(8'h31, 16'h0000);
    rd_chk(8'h31, 16'h0003, "status ignores writes");
    wr(8'h33, 16'h0007);
    irq_chk(1'b0);
    rd_chk(8'h31, 16'h0000, "status cleared");
    rd_chk(8'h33, 16'h0000, "clear reads zero");
    wr_thr(8'h25, 14'h3fff);
    meas(1'b1, 1'b0, 14'h3fff);
    check(cell_overvoltage_alert, 1'b0, "ov disabled");
  endtask

  task automatic t_block_ov;
    wr_thr(8'h28, 14'h1800);
    wr_thr(8'h29, 14'h2000);
    meas(1'b0, 1'b1, 14'h2000);
    check(block_overvoltage_alert, 1'b0, "blk at set");
    meas(1'b0, 1'b1, 14'h2001);
    check(block_overvoltage_alert, 1'b1, "blk above set");
    check(cell_overvoltage_alert, 1'b0, "blk code kept off cell");
    meas(1'b0, 1'b1, 14'h1801);
    check(block_overvoltage_alert, 1'b1, "blk hold");
    meas(1'b0, 1'b1, 14'h1800);
    check(block_overvoltage_alert, 1'b0, "blk at clear");
    rd_chk(8'h31, 16'h0004, "block event status");
    check(irq, 1'b0, "block event masked");
    wr_thr(8'h29, 14'h3fff);
    meas(1'b0, 1'b1, 14'h3fff);
    check(block_overvoltage_alert, 1'b0, "blk disabled");
  endtask

  // ******************************************************************
  // Verdict, watchdog and main sequence
  // ******************************************************************
  task automatic stop_test;
    $display("comparisons %0d mismatches %0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  // The whole sequence needs well under 400 cycles; 2000 leaves margin.
  initial begin
    #(2000 * 25);
    mismatches++;
    $display("unexpected at %0t: watchdog expired", $time);
    stop_test();
  end

  initial begin
    repeat (5) @(posedge sys_clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge sys_clk);
    t_reset_values();
    t_low_bits();
    t_cell_uv();
    t_cell_ov();
    t_block_ov();
    stop_test();
  end

endmodule
